// ==== design/sis_pkg.sv ====
// Purpose: Constants for the system init sequencer
// Assumes: 10 MHz clock, APB register access
// Notes:
package sis_pkg;
    localparam logic [7:0]  SIS_OFS_CTRL    = 8'h00;
    localparam logic [7:0]  SIS_OFS_SEL     = 8'h04;
    localparam logic [7:0]  SIS_OFS_STATUS  = 8'h08;
    localparam logic [7:0]  SIS_OFS_CCR     = 8'h0C;
    localparam logic [7:0]  SIS_OFS_ATR     = 8'h10;
    localparam logic [7:0]  SIS_OFS_MASK    = 8'h14;
    localparam logic [7:0]  SIS_OFS_UNIT    = 8'h18;
    localparam int          SIS_NEL         = 8;
    localparam logic [15:0] SIS_CCR_RST     = 16'h0000;
    localparam logic [15:0] SIS_CCR_SET_CONFIGURATION_COMMAND    = 16'h00FF;
    localparam logic [31:0] SIS_ATR_RST     = 32'h0000_0000;
    localparam int          SIS_ATR_SLOT1_LSB = 4;
    localparam logic [7:0]  SIS_LOC_PSW     = 8'h00;
    localparam logic [7:0]  SIS_LOC_CCW1    = 8'h08;
    localparam logic [7:0]  SIS_LOC_CCW2    = 8'h10;
    localparam logic [7:0]  SIS_PSA_BYTES   = 8'h18;
    localparam int          SIS_CTRL_GO     = 0;
    localparam int          SIS_CTRL_LOAD   = 1;
    localparam int          SIS_CTRL_CONS   = 2;
    localparam int          SIS_CTRL_PWRUP  = 3;
    localparam int          SIS_CTRL_RECONF = 4;
    typedef enum logic [3:0] {
        SIS_IDLE, SIS_RESET, SIS_SLOT, SIS_SET_CONFIGURATION_COMMAND, SIS_SET_TRANSLATION_COMMAND,
        SIS_LOAD, SIS_WAIT, SIS_PSW, SIS_DONE
    } sis_state_t;
endpackage : sis_pkg

// ==== design/sis_top.sv ====
// Purpose: System reset, load and restart sequencer of a computing element
// Assumes: One 10 MHz clock; peer lines synchronous
// Notes: Registers over APB
//
// Implementation choices: the register addresses and the APB interface to the registers.
`timescale 1ns/1ps
`default_nettype none
module sis_top
    import sis_pkg::*;
(
    input  wire logic        CLK_I,
    input  wire logic        RST_N_I,
    input  wire logic        PSEL_I,
    input  wire logic        PENABLE_I,
    input  wire logic        PWRITE_I,
    input  wire logic [7:0]  PADDR_I,
    input  wire logic [31:0] PWDATA_I,
    output logic      [31:0] PRDATA_O,
    output logic             PREADY_O,
    output logic             PSLVERR_O,
    input  wire logic        LOCK_KEY_I,
    input  wire logic        CE_SELECTED_I,
    input  wire logic [7:0]  TEST_STATE0_I,
    input  wire logic [7:0]  CONFIGURED_I,
    input  wire logic [7:0]  UNIT_OWNED_I,
    input  wire logic [7:0]  UNIT_CONFIGURABLE_I,
    input  wire logic        DIAG_MODE_I,
    input  wire logic        STATE01_I,
    input  wire logic        RESPONSE_I,
    output logic             CMD_STROBE_O,
    output logic [7:0]       SYS_RESET_O,
    output logic [7:0]       SUB_RESET_O,
    output logic [7:0]       SET_CONFIGURATION_COMMAND_O,
    output logic             SET_TRANSLATION_COMMAND_O,
    output logic             LOAD_CHANNEL_REQUEST_O,
    output logic             DUMP_DONE_O,
    output logic             CHAN_RESET_O,
    output logic             DEV_RESET_O,
    output logic             PSW_FETCH_O,
    output logic [7:0]       FETCH_ADDR_O,
    output logic             BUSY_O
);
    // ------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------
    sis_state_t  state_q;
    logic        sys_q;
    logic        load_q;
    logic        pwr_q;
    logic        blocked_q;
    logic [3:0]  se_sel_q;
    logic [2:0]  unit_q;
    logic [15:0] ccr_q;
    logic [31:0] atr_q;
    logic [7:0]  mask_q;
    logic        in_reset_q;
    logic        chan_rst_q;
    logic [31:0] prdata_q;
    logic        wr;
    logic        rd;
    logic        go;
    logic        sys_req;
    logic        req_ok;

    function automatic logic [7:0] unit_hot(input logic [2:0] u);
        unit_hot = 8'h01 << u;
    endfunction : unit_hot

    assign wr = PSEL_I && PENABLE_I && PWRITE_I;
    assign rd = PSEL_I && PENABLE_I && !PWRITE_I;
    assign go = wr && (PADDR_I == SIS_OFS_CTRL) && PWDATA_I[SIS_CTRL_GO];
    assign sys_req = PWDATA_I[SIS_CTRL_LOAD] ? LOCK_KEY_I : LOCK_KEY_I;
    assign req_ok = !(PWDATA_I[SIS_CTRL_CONS] && LOCK_KEY_I && CE_SELECTED_I);

    // ------------------------------------------------------------
    // APB slave
    // ------------------------------------------------------------
    assign PREADY_O = 1'b1;
    assign PSLVERR_O = PSEL_I && PENABLE_I && (PADDR_I > SIS_OFS_UNIT);
    assign PRDATA_O = prdata_q;

    always_comb begin
        prdata_q = 32'h0000_0000;
        if (PADDR_I == SIS_OFS_SEL) begin
            prdata_q = {25'h0, unit_q, se_sel_q};
        end else if (PADDR_I == SIS_OFS_STATUS) begin
            prdata_q = {21'h0, blocked_q, in_reset_q, sys_q, load_q, 3'h0, state_q};
        end else if (PADDR_I == SIS_OFS_CCR) begin
            prdata_q = {16'h0, ccr_q};
        end else if (PADDR_I == SIS_OFS_ATR) begin
            prdata_q = atr_q;
        end else if (PADDR_I == SIS_OFS_MASK) begin
            prdata_q = {24'h0, mask_q};
        end else if (PADDR_I == SIS_OFS_UNIT) begin
            prdata_q = {29'h0, unit_q};
        end
    end

    always_ff @(posedge CLK_I) begin
        if (!RST_N_I) begin
            se_sel_q <= 4'h0;
            unit_q   <= 3'h0;
        end else if (wr && (PADDR_I == SIS_OFS_SEL)) begin
            se_sel_q <= PWDATA_I[3:0];
            unit_q   <= PWDATA_I[6:4];
        end
    end

    // ------------------------------------------------------------
    // Sequencer
    // ------------------------------------------------------------
    always_ff @(posedge CLK_I) begin
        if (!RST_N_I) begin
            state_q   <= SIS_IDLE;
            sys_q     <= 1'b0;
            load_q    <= 1'b0;
            pwr_q     <= 1'b0;
            blocked_q <= 1'b0;
        end else begin
            case (state_q)
                SIS_IDLE: begin
                    if (go && PWDATA_I[SIS_CTRL_PWRUP]) begin
                        pwr_q <= 1'b1;
                    end else if (go && !req_ok) begin
                        blocked_q <= 1'b1;
                    end else if (go && !PWDATA_I[SIS_CTRL_LOAD] && !LOCK_KEY_I) begin
                        sys_q     <= 1'b0;
                        load_q    <= 1'b0;
                        blocked_q <= 1'b0;
                        state_q   <= SIS_RESET;
                    end else if (go) begin
                        sys_q     <= sys_req;
                        load_q    <= PWDATA_I[SIS_CTRL_LOAD];
                        blocked_q <= 1'b0;
                        state_q   <= SIS_RESET;
                    end else begin
                        pwr_q <= 1'b0;
                    end
                end
                SIS_RESET: state_q <= sys_q ? SIS_SLOT : (load_q ? SIS_SET_TRANSLATION_COMMAND : SIS_PSW);
                SIS_SLOT:  state_q <= SIS_SET_CONFIGURATION_COMMAND;
                SIS_SET_CONFIGURATION_COMMAND:  state_q <= SIS_SET_TRANSLATION_COMMAND;
                SIS_SET_TRANSLATION_COMMAND:  state_q <= load_q ? SIS_LOAD : SIS_PSW;
                SIS_LOAD:  state_q <= SIS_WAIT;
                SIS_WAIT:  state_q <= RESPONSE_I ? SIS_PSW : SIS_WAIT;
                SIS_PSW:   state_q <= SIS_DONE;
                SIS_DONE:  state_q <= SIS_IDLE;
                default:   state_q <= SIS_IDLE;
            endcase
        end
    end

    // ------------------------------------------------------------
    // Configuration and translation state
    // ------------------------------------------------------------
    always_ff @(posedge CLK_I) begin
        if (!RST_N_I) begin
            ccr_q <= SIS_CCR_RST;
            atr_q <= SIS_ATR_RST;
        end else if ((state_q == SIS_RESET && sys_q) || pwr_q) begin
            ccr_q <= SIS_CCR_SET_CONFIGURATION_COMMAND;
            atr_q <= SIS_ATR_RST;
        end else if (state_q == SIS_SLOT) begin
            atr_q[SIS_ATR_SLOT1_LSB +: 4] <= se_sel_q;
        end else if (wr && PADDR_I == SIS_OFS_CCR && !in_reset_q) begin
            ccr_q <= PWDATA_I[15:0];
        end
    end

    always_ff @(posedge CLK_I) begin
        if (!RST_N_I) begin
            mask_q <= 8'h00;
        end else if (wr && PADDR_I == SIS_OFS_MASK) begin
            mask_q <= PWDATA_I[7:0];
        end
    end

    always_ff @(posedge CLK_I) begin
        if (!RST_N_I) begin
            in_reset_q <= 1'b0;
        end else if (state_q == SIS_RESET || pwr_q) begin
            in_reset_q <= 1'b1;
        end else if (state_q == SIS_DONE || (state_q == SIS_IDLE && !pwr_q)) begin
            in_reset_q <= 1'b0;
        end
    end

    always_ff @(posedge CLK_I) begin
        if (!RST_N_I) begin
            chan_rst_q <= 1'b0;
        end else begin
            chan_rst_q <= (state_q == SIS_RESET) ||
                          (wr && PADDR_I == SIS_OFS_CTRL && PWDATA_I[SIS_CTRL_RECONF] &&
                           DIAG_MODE_I && STATE01_I);
        end
    end

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    always_ff @(posedge CLK_I) begin
        if (!RST_N_I) begin
            SYS_RESET_O            <= 8'h00;
            SUB_RESET_O            <= 8'h00;
            SET_CONFIGURATION_COMMAND_O                 <= 8'h00;
            SET_TRANSLATION_COMMAND_O                 <= 1'b0;
            LOAD_CHANNEL_REQUEST_O <= 1'b0;
            DUMP_DONE_O            <= 1'b0;
            CHAN_RESET_O           <= 1'b0;
            DEV_RESET_O            <= 1'b0;
            PSW_FETCH_O            <= 1'b0;
            FETCH_ADDR_O           <= 8'h00;
            CMD_STROBE_O           <= 1'b0;
            BUSY_O                 <= 1'b0;
        end else begin
            SYS_RESET_O  <= (state_q == SIS_RESET && sys_q) ? ~TEST_STATE0_I : 8'h00;
            SUB_RESET_O  <= (state_q == SIS_RESET && !sys_q) ?
                            (CONFIGURED_I & (UNIT_OWNED_I | ~UNIT_CONFIGURABLE_I)) :
                            8'h00;
            DUMP_DONE_O  <= state_q == SIS_RESET && !sys_q;
            SET_CONFIGURATION_COMMAND_O       <= (state_q == SIS_SET_CONFIGURATION_COMMAND) ? mask_q : 8'h00;
            SET_TRANSLATION_COMMAND_O       <= state_q == SIS_SET_TRANSLATION_COMMAND;
            CMD_STROBE_O <= state_q == SIS_SET_CONFIGURATION_COMMAND || state_q == SIS_SET_TRANSLATION_COMMAND;
            LOAD_CHANNEL_REQUEST_O <= (state_q == SIS_LOAD) ||
                                      (state_q == SIS_WAIT && !RESPONSE_I);
            CHAN_RESET_O <= chan_rst_q;
            DEV_RESET_O  <= chan_rst_q;
            PSW_FETCH_O  <= state_q == SIS_PSW;
            FETCH_ADDR_O <= (state_q == SIS_LOAD) ? SIS_LOC_CCW1 : SIS_LOC_PSW;
            BUSY_O       <= state_q != SIS_IDLE;
        end
    end
    // PREFIX_SAVE_AREA layout is read by the channel element: SIS_LOC_CCW2, SIS_PSA_BYTES.
    logic unused_ok;
    assign unused_ok = ^{SIS_LOC_CCW2, SIS_PSA_BYTES, unit_hot(unit_q)};
endmodule : sis_top
`default_nettype wire

// ==== bench/sis_monitor.sv ====
// Purpose: Port checker for sis_top
// Assumes: Bench holds peer levels steady during a sequence
// Notes: Bound from the testbench top file
`timescale 1ns/1ps
`default_nettype none
module sis_chk
    import sis_pkg::*;
(
    input wire logic       CLK_I,
    input wire logic       RST_N_I,
    input wire logic       PSEL_I,
    input wire logic       PENABLE_I,
    input wire logic [7:0] PADDR_I,
    input wire logic       PSLVERR_O,
    input wire logic       LOCK_KEY_I,
    input wire logic [7:0] TEST_STATE0_I,
    input wire logic [7:0] CONFIGURED_I,
    input wire logic       RESPONSE_I,
    input wire logic [7:0] SYS_RESET_O,
    input wire logic [7:0] SUB_RESET_O,
    input wire logic [7:0] SET_CONFIGURATION_COMMAND_O,
    input wire logic       SET_TRANSLATION_COMMAND_O,
    input wire logic       LOAD_CHANNEL_REQUEST_O,
    input wire logic       DUMP_DONE_O,
    input wire logic       CHAN_RESET_O,
    input wire logic       DEV_RESET_O,
    input wire logic       PSW_FETCH_O,
    input wire logic [7:0] FETCH_ADDR_O,
    input wire logic       BUSY_O
);
    logic set_translation_command_q;
    always_ff @(posedge CLK_I) begin
        if (!RST_N_I) begin
            set_translation_command_q <= 1'b0;
        end else begin
            set_translation_command_q <= SET_TRANSLATION_COMMAND_O | (set_translation_command_q & BUSY_O);
        end
    end
    default clocking @(posedge CLK_I); endclocking
    default disable iff (!RST_N_I);
    sequence chan_then_dev;
        CHAN_RESET_O ##[0:2] DEV_RESET_O;
    endsequence
    a_sys_skip_test: assert property ((SYS_RESET_O & $past(TEST_STATE0_I)) == 8'h00)
        else $error("system reset hit excluded element");
    a_sub_only_cfg: assert property ((SUB_RESET_O & ~$past(CONFIGURED_I)) == 8'h00)
        else $error("subsystem reset outside subsystem");
    a_sub_keep_cfg: assert property (|SUB_RESET_O |-> SET_CONFIGURATION_COMMAND_O == 8'h00)
        else $error("configuration sent with subsystem reset");
    a_dump_on_sub: assert property (|SUB_RESET_O |-> ##[0:2] DUMP_DONE_O)
        else $error("no dump done with subsystem reset");
    a_dev_follows: assert property (CHAN_RESET_O |-> chan_then_dev)
        else $error("device reset missing");
    a_req_held: assert property (LOAD_CHANNEL_REQUEST_O && !RESPONSE_I |=> LOAD_CHANNEL_REQUEST_O)
        else $error("load request dropped early");
    a_req_ends: assert property (LOAD_CHANNEL_REQUEST_O && RESPONSE_I |-> ##[1:3] !LOAD_CHANNEL_REQUEST_O)
        else $error("load request not released");
    a_req_after_set_translation_command: assert property ($rose(LOAD_CHANNEL_REQUEST_O) |-> set_translation_command_q || SET_TRANSLATION_COMMAND_O)
        else $error("load request before translation");
    a_set_configuration_command_lock: assert property (|SET_CONFIGURATION_COMMAND_O |-> LOCK_KEY_I)
        else $error("configuration command without lock key");
    a_psw_zero: assert property (PSW_FETCH_O |-> FETCH_ADDR_O == SIS_LOC_PSW)
        else $error("status word not fetched from zero");
    a_err_high: assert property (PSEL_I && PENABLE_I && PADDR_I > 8'h18 |-> PSLVERR_O)
        else $error("unmapped access not flagged");
endmodule : sis_chk
`default_nettype wire

// ==== bench/sis_peer.sv ====
// Purpose: Channel element model answering load requests
// Assumes: Response is a level held until request drops
// Notes: LAT sets answer delay
`timescale 1ns/1ps
`default_nettype none
module sis_peer #(parameter int LAT = 5) (
    input  wire logic clk_i,
    input  wire logic rst_n_i,
    input  wire logic req_i,
    output var logic  resp_o
);
    int cnt;
    // Bootstrap read and command chain run as a delay
    always @(posedge clk_i) begin
        if (!rst_n_i || !req_i) begin
            cnt <= 0;
            resp_o <= 1'b0;
        end else if (cnt == LAT) begin
            resp_o <= 1'b1;
        end else begin
            cnt <= cnt + 1;
        end
    end
endmodule : sis_peer
`default_nettype wire

// ==== bench/testbench.sv ====
// Purpose: Sequence tests of sis_top over APB
// Assumes: Peer levels change only between sequences
// Notes: Outputs gathered on falling edges
`timescale 1ns/1ps
`default_nettype none
module testbench
    import sis_pkg::*;
;
    logic CLK_I = 0, RST_N_I, PSEL_I, PENABLE_I, PWRITE_I, LOCK_KEY_I, CE_SELECTED_I;
    logic DIAG_MODE_I, STATE01_I, RESPONSE_I, PREADY_O, PSLVERR_O, CMD_STROBE_O, SET_TRANSLATION_COMMAND_O;
    logic LOAD_CHANNEL_REQUEST_O, DUMP_DONE_O, CHAN_RESET_O, DEV_RESET_O, PSW_FETCH_O, BUSY_O;
    logic [7:0] PADDR_I, TEST_STATE0_I, CONFIGURED_I, UNIT_OWNED_I, UNIT_CONFIGURABLE_I;
    logic [7:0] SYS_RESET_O, SUB_RESET_O, SET_CONFIGURATION_COMMAND_O, FETCH_ADDR_O, sys_s, sub_s, set_configuration_command_s;
    logic [31:0] PWDATA_I, PRDATA_O, r;
    logic [5:0] fl_s;
    logic perr;
    int errors = 0, n_checks = 0;
    sis_top DUT (
        .CLK_I(CLK_I), .RST_N_I(RST_N_I), .PSEL_I(PSEL_I), .PENABLE_I(PENABLE_I),
        .PWRITE_I(PWRITE_I), .PADDR_I(PADDR_I), .PWDATA_I(PWDATA_I), .PRDATA_O(PRDATA_O),
        .PREADY_O(PREADY_O), .PSLVERR_O(PSLVERR_O), .LOCK_KEY_I(LOCK_KEY_I),
        .CE_SELECTED_I(CE_SELECTED_I), .TEST_STATE0_I(TEST_STATE0_I),
        .CONFIGURED_I(CONFIGURED_I), .UNIT_OWNED_I(UNIT_OWNED_I),
        .UNIT_CONFIGURABLE_I(UNIT_CONFIGURABLE_I), .DIAG_MODE_I(DIAG_MODE_I),
        .STATE01_I(STATE01_I), .RESPONSE_I(RESPONSE_I), .CMD_STROBE_O(CMD_STROBE_O),
        .SYS_RESET_O(SYS_RESET_O), .SUB_RESET_O(SUB_RESET_O), .SET_CONFIGURATION_COMMAND_O(SET_CONFIGURATION_COMMAND_O),
        .SET_TRANSLATION_COMMAND_O(SET_TRANSLATION_COMMAND_O), .LOAD_CHANNEL_REQUEST_O(LOAD_CHANNEL_REQUEST_O),
        .DUMP_DONE_O(DUMP_DONE_O), .CHAN_RESET_O(CHAN_RESET_O), .DEV_RESET_O(DEV_RESET_O),
        .PSW_FETCH_O(PSW_FETCH_O), .FETCH_ADDR_O(FETCH_ADDR_O), .BUSY_O(BUSY_O));
    sis_peer #(.LAT(6)) PEER (.clk_i(CLK_I), .rst_n_i(RST_N_I),
        .req_i(LOAD_CHANNEL_REQUEST_O), .resp_o(RESPONSE_I));
    always #50 CLK_I = ~CLK_I;
    always @(negedge CLK_I) begin
        sys_s |= SYS_RESET_O;
        sub_s |= SUB_RESET_O;
        set_configuration_command_s |= SET_CONFIGURATION_COMMAND_O;
        fl_s |= {SET_TRANSLATION_COMMAND_O, LOAD_CHANNEL_REQUEST_O, DUMP_DONE_O, CHAN_RESET_O, DEV_RESET_O,
            PSW_FETCH_O};
    end
    task automatic complete_run();
        $display("checks=%0d errors=%0d", n_checks, errors);
        if (errors == 0 && n_checks > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask : complete_run
    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        n_checks++;
        if (g !== e) begin
            errors++;
            $display("ERROR t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask : chk
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        PSEL_I <= 1'b1;
        PWRITE_I <= w;
        PADDR_I <= a;
        PWDATA_I <= d;
        @(posedge CLK_I);
        PENABLE_I <= 1'b1;
        do @(posedge CLK_I); while (PREADY_O !== 1'b1);
        r = PRDATA_O;
        perr = PSLVERR_O;
        PSEL_I <= 1'b0;
        PENABLE_I <= 1'b0;
        @(posedge CLK_I);
    endtask : apb
    task automatic run(input logic [31:0] c);
        {sys_s, sub_s, set_configuration_command_s, fl_s} = '0;
        apb(1'b1, SIS_OFS_CTRL, c);
        repeat (3) @(posedge CLK_I);
        repeat (200) if (BUSY_O !== 1'b0) @(posedge CLK_I);
        chk(BUSY_O, 1'b0);
    endtask : run
    initial begin
        {RST_N_I, PSEL_I, PENABLE_I, PWRITE_I, PADDR_I, PWDATA_I} = '0;
        {CE_SELECTED_I, DIAG_MODE_I, STATE01_I} = '0;
        LOCK_KEY_I = 1'b1;
        TEST_STATE0_I = 8'h80;
        CONFIGURED_I = 8'h33;
        UNIT_OWNED_I = 8'h04;
        UNIT_CONFIGURABLE_I = 8'h06;
        repeat (10) @(posedge CLK_I);
        RST_N_I <= 1'b1;
        @(posedge CLK_I);
        apb(1'b0, SIS_OFS_ATR, 32'h0);
        chk(r, SIS_ATR_RST);
        apb(1'b1, SIS_OFS_SEL, 32'h25);
        apb(1'b1, SIS_OFS_MASK, 32'h0F);
        run(32'h3);
        chk(sys_s, 8'h7F);
        chk(set_configuration_command_s, 8'h0F);
        chk(fl_s, 6'h37);
        apb(1'b0, SIS_OFS_CCR, 32'h0);
        chk(r, {16'h0, SIS_CCR_SET_CONFIGURATION_COMMAND});
        apb(1'b0, SIS_OFS_ATR, 32'h0);
        chk(r, 32'h50);
        LOCK_KEY_I <= 1'b0;
        run(32'h3);
        chk({sys_s, set_configuration_command_s, sub_s}, 24'h31);
        chk(fl_s[5:3], 3'h7);
        apb(1'b0, SIS_OFS_ATR, 32'h0);
        chk(r, 32'h50);
        run(32'h1);
        chk({sub_s, fl_s[5:4], fl_s[0]}, 11'h189);
        LOCK_KEY_I <= 1'b1;
        run(32'h1);
        chk({sys_s, fl_s[5:4], fl_s[0]}, 11'h3FD);
        CE_SELECTED_I <= 1'b1;
        run(32'h7);
        chk(sys_s, 8'h00);
        apb(1'b0, SIS_OFS_STATUS, 32'h0);
        chk(r[10], 1'b1);
        CE_SELECTED_I <= 1'b0;
        run(32'h9);
        chk({sys_s, sub_s, fl_s}, 22'h0);
        DIAG_MODE_I <= 1'b1;
        STATE01_I <= 1'b1;
        run(32'h10);
        chk(fl_s[2:1], 2'h3);
        apb(1'b0, 8'h1C, 32'h0);
        chk(perr, 1'b1);
        complete_run();
    end
    initial begin
        repeat (20000) @(posedge CLK_I);
        errors++;
        complete_run();
    end
endmodule : testbench
bind sis_top sis_chk u_chk (
    .CLK_I(CLK_I), .RST_N_I(RST_N_I), .PSEL_I(PSEL_I), .PENABLE_I(PENABLE_I),
    .PADDR_I(PADDR_I), .PSLVERR_O(PSLVERR_O), .LOCK_KEY_I(LOCK_KEY_I),
    .TEST_STATE0_I(TEST_STATE0_I), .CONFIGURED_I(CONFIGURED_I), .RESPONSE_I(RESPONSE_I),
    .SYS_RESET_O(SYS_RESET_O), .SUB_RESET_O(SUB_RESET_O), .SET_CONFIGURATION_COMMAND_O(SET_CONFIGURATION_COMMAND_O),
    .SET_TRANSLATION_COMMAND_O(SET_TRANSLATION_COMMAND_O), .LOAD_CHANNEL_REQUEST_O(LOAD_CHANNEL_REQUEST_O),
    .DUMP_DONE_O(DUMP_DONE_O), .CHAN_RESET_O(CHAN_RESET_O), .DEV_RESET_O(DEV_RESET_O),
    .PSW_FETCH_O(PSW_FETCH_O), .FETCH_ADDR_O(FETCH_ADDR_O), .BUSY_O(BUSY_O));
`default_nettype wire
